// *** src/instr_group_dependency_checker.sv ***
/*
 * Per-group resource dependency checker. One instruction per cycle arrives
 * from decode in program order; faults are reported in order, one cycle
 * later. Assumes decode marks entry points and redirects.
 */
`timescale 1ns/100ps
`default_nettype none
`include "dep_check_params.svh"
module instr_group_dependency_checker #(
    parameter bit DETECT_EN = 1'b1
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire dep_check_pkg::instr_s INSTR,
    input wire logic [7:0] INSTR_TAG,
    output dep_check_pkg::fault_s FAULT,
    output logic [`FPS_BITS-1:0] FP_STATUS,
    output logic FRAME_FWD,
    output logic CHECK_FWD,
    output logic BRANCH_FWD
);
    // ----------------------------------------------------------------
    // Group boundary and activity
    // ----------------------------------------------------------------
    logic boundary;
    logic act;
    logic clear;
    logic redirect_ff;
    logic [`NUM_PRED-1:0] pred_wr_eff;
    logic [`NUM_PRED-1:0] pred_rd_br;
    logic [`NUM_PRED-1:0] waw_vec;
    logic [`NUM_PRED-1:0] written_vec;
    logic [`NUM_PRED-1:0] brread_vec;

    // Entry point starts a fresh group; earlier slots never take part
    assign boundary = INSTR.valid && INSTR.group_start;
    assign clear = boundary;
    // Disabled ordinary branches drop out; loop branches never do
    assign act = INSTR.valid && (INSTR.pred_on || INSTR.is_loop_branch);

    always_comb begin
        pred_wr_eff = act ? INSTR.pred_wr : '0;
        if (act && INSTR.is_mod_loop) begin
            pred_wr_eff[`PRED_LOOP] = 1'b1;
        end
        pred_rd_br = (act && INSTR.is_branch) ? INSTR.pred_rd : '0;
    end

    // ----------------------------------------------------------------
    // Predicate tracking, one slice per predicate
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `NUM_PRED; gi++) begin : g_pred
            pred_waw_slice u_slice (
                .clk(CLK),
                .srst(SRST),
                .clear(clear),
                .wr(pred_wr_eff[gi]),
                .br_rd(pred_rd_br[gi]),
                .cmp_type(INSTR.cmp_type),
                .is_zero(gi == 0),
                .waw_bad(waw_vec[gi]),
                .written(written_vec[gi]),
                .branch_read(brread_vec[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // What the incoming instruction adds to the group state
    // ----------------------------------------------------------------
    // The entry instruction loads the fresh state itself; a plain clear
    // would drop the first writer of every group.
    logic [`NUM_PRED-1:0] fp_pred_in;
    logic [`NUM_BR-1:0] br_wr_in;
    logic [`NUM_BR-1:0] br_by_br_in;
    logic pfs_nb_in;
    logic pfs_br_in;
    logic lc_wr_in;
    logic frame_wr_in;
    logic [`NAT_BITS-1:0] spill_in;
    logic move_wr_in;
    logic check_in;
    logic [`NAT_BITS-1:0] nat_one;
    logic [`NUM_BR-1:0] br_rd_eff;

    assign nat_one = `NAT_BITS'(1) << INSTR.nat_bit;
    // Indirect prediction hint counts as a branch register reader
    assign br_rd_eff = (act || (INSTR.valid && INSTR.is_brp_ind))
        ? INSTR.br_rd : '0;
    assign fp_pred_in = (act && INSTR.is_fp) ? pred_wr_eff : '0;
    assign br_wr_in = act ? INSTR.br_wr : '0;
    assign br_by_br_in = (act && INSTR.is_branch) ? INSTR.br_wr : '0;
    assign pfs_nb_in = act && INSTR.pfs_wr && !INSTR.is_branch;
    assign pfs_br_in = act && INSTR.pfs_wr && INSTR.is_branch;
    assign lc_wr_in = act && INSTR.lc_wr;
    assign frame_wr_in = act && INSTR.frame_wr;
    assign spill_in = (act && INSTR.nat_spill_wr) ? nat_one : '0;
    assign move_wr_in = act && INSTR.nat_move_wr;
    assign check_in = act && INSTR.is_check_load;

    // ----------------------------------------------------------------
    // Other resource state of the current group
    // ----------------------------------------------------------------
    logic [`NUM_PRED-1:0] pred_fp_wr_ff;
    logic [`NUM_BR-1:0] br_wr_ff;
    logic [`NUM_BR-1:0] br_by_br_ff;
    logic frame_wr_ff;
    logic pfs_wr_ff;
    logic pfs_br_wr_ff;
    logic lc_wr_ff;
    logic nat_move_wr_ff;
    logic [`NAT_BITS-1:0] nat_spill_ff;
    logic check_tgt_ff;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            pred_fp_wr_ff <= '0;
        end else begin
            pred_fp_wr_ff <= (clear ? '0 : pred_fp_wr_ff) | fp_pred_in;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            br_wr_ff <= '0;
        end else begin
            br_wr_ff <= (clear ? '0 : br_wr_ff) | br_wr_in;
        end
    end

    // Branch-written branch registers are not visible to a later branch
    always_ff @(posedge CLK) begin
        if (SRST) begin
            br_by_br_ff <= '0;
        end else begin
            br_by_br_ff <= (clear ? '0 : br_by_br_ff) | br_by_br_in;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            pfs_wr_ff <= 1'b0;
        end else begin
            pfs_wr_ff <= (pfs_wr_ff && !clear) || pfs_nb_in;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            pfs_br_wr_ff <= 1'b0;
        end else begin
            pfs_br_wr_ff <= (pfs_br_wr_ff && !clear) || pfs_br_in;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            lc_wr_ff <= 1'b0;
        end else begin
            lc_wr_ff <= (lc_wr_ff && !clear) || lc_wr_in;
        end
    end

    // Frame marker is one indivisible resource
    always_ff @(posedge CLK) begin
        if (SRST) begin
            frame_wr_ff <= 1'b0;
        end else begin
            frame_wr_ff <= (frame_wr_ff && !clear) || frame_wr_in;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            nat_spill_ff <= '0;
        end else begin
            nat_spill_ff <= (clear ? '0 : nat_spill_ff) | spill_in;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            nat_move_wr_ff <= 1'b0;
        end else begin
            nat_move_wr_ff <= (nat_move_wr_ff && !clear) || move_wr_in;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            check_tgt_ff <= 1'b0;
        end else begin
            check_tgt_ff <= (check_tgt_ff && !clear) || check_in;
        end
    end

    // ----------------------------------------------------------------
    // Violation detection for the incoming instruction
    // ----------------------------------------------------------------
    logic raw_hit;
    logic waw_hit;
    logic war_hit;
    logic nat_raw;
    logic nat_waw;
    logic pred_raw;

    // Non-branch readers of a predicate written in-group; branches only
    // fault when the writer was floating point
    always_comb begin
        pred_raw = 1'b0;
        if (act) begin
            if (INSTR.is_branch) begin
                pred_raw = |(INSTR.pred_rd & pred_fp_wr_ff & ~`NUM_PRED'(1));
            end else begin
                pred_raw = |(INSTR.pred_rd & written_vec & ~`NUM_PRED'(1));
            end
        end
    end

    always_comb begin
        nat_raw = act && ((INSTR.nat_fill_rd && (nat_move_wr_ff
            || |(nat_spill_ff & nat_one)))
            || (INSTR.nat_move_rd && |nat_spill_ff));
        nat_waw = act && ((INSTR.nat_spill_wr && (nat_move_wr_ff
            || |(nat_spill_ff & nat_one)))
            || (INSTR.nat_move_wr && (nat_move_wr_ff || |nat_spill_ff)));
    end

    always_comb begin
        // Branch reads of branch regs and pfs see only non-branch in-group writes
        raw_hit = pred_raw || nat_raw
            || |(br_rd_eff & (INSTR.is_branch ? br_by_br_ff : br_wr_ff))
            || (act && INSTR.pfs_rd && (INSTR.is_branch ? pfs_br_wr_ff
                : (pfs_wr_ff || pfs_br_wr_ff)))
            || (act && INSTR.lc_rd && lc_wr_ff);
        waw_hit = nat_waw || (|waw_vec)
            || (act && |(INSTR.br_wr & br_wr_ff))
            || (act && INSTR.frame_wr && frame_wr_ff)
            || (act && INSTR.lc_wr && lc_wr_ff)
            || (act && INSTR.pfs_wr && (pfs_wr_ff || pfs_br_wr_ff));
        // Predicate 63 read by a branch, then written by a modulo loop
        war_hit = act && INSTR.is_mod_loop && brread_vec[`PRED_LOOP];
    end

    // ----------------------------------------------------------------
    // In-order fault delivery on the second operation
    // ----------------------------------------------------------------
    logic fault_hold_ff;

    // A redirect between two operations cancels the pairing: the group
    // state restarts, since the target is an entry point.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            redirect_ff <= 1'b0;
        end else if (INSTR.valid) begin
            redirect_ff <= INSTR.is_redirect;
        end
    end

    // One fault per group: the earliest instruction wins
    always_ff @(posedge CLK) begin
        if (SRST || clear || redirect_ff) begin
            fault_hold_ff <= 1'b0;
        end else if (FAULT.fault) begin
            fault_hold_ff <= 1'b1;
        end
    end

    logic fault_fire;
    logic [1:0] kind_nxt;
    logic fault_ff;
    logic [1:0] kind_ff;
    logic [7:0] tag_ff;

    assign fault_fire = DETECT_EN && !boundary && !redirect_ff && !fault_hold_ff
        && !fault_ff && (raw_hit || waw_hit || war_hit);
    assign kind_nxt = raw_hit ? 2'(dep_check_pkg::VIO_RAW)
        : waw_hit ? 2'(dep_check_pkg::VIO_WAW)
        : 2'(dep_check_pkg::VIO_WAR);
    assign FAULT = {fault_ff, kind_ff, tag_ff};

    always_ff @(posedge CLK) begin
        if (SRST) begin
            fault_ff <= 1'b0;
        end else begin
            fault_ff <= fault_fire;
        end
    end

    // Kind reads as none between pulses
    always_ff @(posedge CLK) begin
        if (SRST || !fault_fire) begin
            kind_ff <= 2'(dep_check_pkg::VIO_NONE);
        end else begin
            kind_ff <= kind_nxt;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            tag_ff <= 8'h00;
        end else if (fault_fire) begin
            tag_ff <= INSTR_TAG;
        end
    end

    // ----------------------------------------------------------------
    // Same-group forwarding indications for the datapath
    // ----------------------------------------------------------------
    logic fwd_ok;

    // An entry instruction sees only the previous group's state
    assign fwd_ok = act && !boundary;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            FRAME_FWD <= 1'b0;
        end else begin
            // Stacked accessors after a resize use the new frame
            FRAME_FWD <= fwd_ok && INSTR.frame_rd && frame_wr_ff;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            CHECK_FWD <= 1'b0;
        end else begin
            // Reader of a check load target takes the loaded value
            CHECK_FWD <= fwd_ok && check_tgt_ff && !INSTR.is_check_load;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            BRANCH_FWD <= 1'b0;
        end else begin
            BRANCH_FWD <= fwd_ok && INSTR.is_branch
                && (|(br_rd_eff & br_wr_ff & ~br_by_br_ff)
                || (INSTR.pfs_rd && pfs_wr_ff)
                || |(INSTR.pred_rd & written_vec & ~pred_fp_wr_ff));
        end
    end

    fp_status_merge #(
        .W(`FPS_BITS)
    ) u_fps (
        .clk(CLK),
        .srst(SRST),
        .boundary(boundary),
        .wr(act && INSTR.is_fp),
        .val(INSTR.fp_status),
        .committed(FP_STATUS)
    );
endmodule // instr_group_dependency_checker
`default_nettype wire

// *** src/dep_check_params.svh ***
/*
 * Constants of the instruction group dependency checker: resource field
 * positions, widths and timing. Assumes inclusion by bare name.
 */
// What this block does
// - stacked registers see new frame after resize
// - reader after check load sees loaded value
// - non-branch branch-reg/pfs/frame writes visible to branch
// - non-fp predicate writes visible; fp-to-branch faults
// - disabled ordinary branches touch no resource
// - loop branches always read and write
// - indirect prediction hint reads its branch reg
// - nat collection RAW per bit; vs move faults
// - frame marker tracked as one resource
// - compares share predicate if all and/or
// - predicate zero WAW always allowed
// - mask-limited predicate moves; other WAW faults
// - fp status writes merge by bitwise OR
// - spill stores distinct nat bits; move faults
// - p63 branch read then loop write faults
// - first detected violation of a group raises a fault
// - fault lands on second operation
// - faults in order; suppressed by redirect between
// - nothing before entry point is checked
// - group ends at stop, taken branch, faults
// - predicate zero free of restrictions, reads one
`ifndef DEP_CHECK_PARAMS_SVH
`define DEP_CHECK_PARAMS_SVH

`define NUM_PRED 64
`define NUM_BR 8
`define NAT_BITS 64
`define FPS_BITS 16
`define PRED_LOOP 6'h3F
// Class codes carried in the instruction record
`define CMP_NONE 2'h0
`define CMP_AND 2'h1
`define CMP_OR 2'h2
`define CMP_PLAIN 2'h3
// Fault latency from issue to report, in ns and in cycles at 200 MHz
`define FAULT_LAT_NS 5
`define FAULT_LAT_CYC (((`FAULT_LAT_NS * 200) + 999) / 1000)

`endif

// *** src/dep_check_pkg.sv ***
/*
 * Types of the dependency checker: the instruction record from decode and
 * the fault report. Assumes the params header is compiled alongside.
 */
`include "dep_check_params.svh"
package dep_check_pkg;
    // One issued instruction, as decode describes it
    typedef struct packed {
        logic valid;
        logic group_start;      // Entry point: stop or branch target slot
        logic pred_on;          // Qualifying predicate true
        logic is_branch;
        logic is_loop_branch;   // Counted or modulo loop, always active
        logic is_mod_loop;      // Modulo loop, writes predicate 63
        logic is_fp;
        logic is_brp_ind;
        logic is_frame_resize;
        logic is_check_load;
        logic is_redirect;      // Taken branch, interruption, check taken
        logic [1:0] cmp_type;
        logic [`NUM_PRED-1:0] pred_rd;
        logic [`NUM_PRED-1:0] pred_wr;
        logic [`NUM_BR-1:0] br_rd;
        logic [`NUM_BR-1:0] br_wr;
        logic frame_rd;
        logic frame_wr;
        logic pfs_rd;
        logic pfs_wr;
        logic lc_rd;
        logic lc_wr;
        logic nat_move_rd;
        logic nat_move_wr;
        logic nat_fill_rd;
        logic nat_spill_wr;
        logic [5:0] nat_bit;
        logic [`FPS_BITS-1:0] fp_status;
    } instr_s;

    typedef enum {VIO_NONE, VIO_RAW, VIO_WAW, VIO_WAR} vio_kind_e;

    typedef struct packed {
        logic fault;
        logic [1:0] kind;
        logic [7:0] tag;
    } fault_s;
endpackage

// *** src/pred_waw_slice.sv ***
/*
 * One predicate's group state: written-by-type and read-by-branch flags.
 * Assumes the parent clears it on every group boundary.
 */
`timescale 1ns/100ps
`default_nettype none
`include "dep_check_params.svh"
module pred_waw_slice (
    input wire logic clk,
    input wire logic srst,
    input wire logic clear,
    input wire logic wr,
    input wire logic br_rd,
    input wire logic [1:0] cmp_type,
    input wire logic is_zero,
    output logic waw_bad,
    output logic written,
    output logic branch_read
);
    logic [1:0] type_ff;

    // The entry instruction's own write opens the new group state
    always_ff @(posedge clk) begin
        if (srst) begin
            written <= 1'b0;
            type_ff <= `CMP_NONE;
        end else if (clear || wr) begin
            written <= wr;
            type_ff <= wr ? cmp_type : `CMP_NONE;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            branch_read <= 1'b0;
        end else if (clear || br_rd) begin
            branch_read <= br_rd;
        end
    end

    // Same and/or kind may merge; predicate zero never conflicts
    always_comb begin
        waw_bad = wr && written && !is_zero
            && !(type_ff == cmp_type && (cmp_type == `CMP_AND
            || cmp_type == `CMP_OR));
    end
endmodule // pred_waw_slice
`default_nettype wire

// *** src/fp_status_merge.sv ***
/*
 * Accumulates floating-point status writes of a group by bitwise OR and
 * commits at the boundary. Assumes one writer per cycle.
 */
`timescale 1ns/100ps
`default_nettype none
`include "dep_check_params.svh"
module fp_status_merge #(
    parameter int W = `FPS_BITS
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic boundary,
    input wire logic wr,
    input wire logic [W-1:0] val,
    output logic [W-1:0] committed
);
    logic [W-1:0] acc_ff;

    always_ff @(posedge clk) begin
        if (srst) begin
            acc_ff <= '0;
        end else if (boundary) begin
            acc_ff <= wr ? val : '0;
        end else if (wr) begin
            acc_ff <= acc_ff | val;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            committed <= '0;
        end else if (boundary) begin
            committed <= committed | acc_ff;
        end
    end
endmodule // fp_status_merge
`default_nettype wire

// *** dv/dep_rule_monitor.sv ***
/*
 * Port-level checker for the instruction group dependency checker.
 * Assumes one clock, synchronous active-high reset, bound by name below.
 */
`timescale 1ns/100ps
`default_nettype none
`include "dep_check_params.svh"
module dep_rule_monitor #(
    parameter bit DETECT_EN = 1'b1
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire dep_check_pkg::instr_s INSTR,
    input wire logic [7:0] INSTR_TAG,
    input wire dep_check_pkg::fault_s FAULT,
    input wire logic [`FPS_BITS-1:0] FP_STATUS,
    input wire logic FRAME_FWD,
    input wire logic CHECK_FWD,
    input wire logic BRANCH_FWD
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    sequence s_entry;
        INSTR.valid && INSTR.group_start;
    endsequence
    sequence s_redirect;
        INSTR.valid && INSTR.is_redirect;
    endsequence
    sequence s_next;
        INSTR.valid;
    endsequence

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    reset_clear_a: assert property (disable iff (1'b0) SRST |=> FAULT == '0
        && !FRAME_FWD && !CHECK_FWD && !BRANCH_FWD && FP_STATUS == '0)
        else $error("outputs not cleared by reset");
    fault_pulse_a: assert property (FAULT.fault |=> !FAULT.fault)
        else $error("fault held longer than one cycle");
    fault_source_a: assert property (FAULT.fault |-> $past(INSTR.valid)
        && FAULT.tag == $past(INSTR_TAG)) else $error("fault not on the second operation");
    entry_nofault_a: assert property (s_entry |=> !FAULT.fault)
        else $error("entry point instruction faulted");
    redirect_quiet_a: assert property (s_redirect ##1 s_next |=> !FAULT.fault)
        else $error("fault raised across a redirect");
    fault_kind_a: assert property (FAULT.fault |-> FAULT.kind != 2'h0)
        else $error("fault without a kind");
    detect_off_a: assert property (FAULT.fault |-> DETECT_EN)
        else $error("fault with detection absent");
    fp_accum_a: assert property (!$past(SRST) |-> (FP_STATUS | $past(FP_STATUS)) == FP_STATUS)
        else $error("fp status lost a bit");
    frame_fwd_a: assert property (FRAME_FWD |-> $past(INSTR.valid) && !$past(INSTR.group_start))
        else $error("frame forward without a same group reader");
    check_fwd_a: assert property (CHECK_FWD |-> $past(INSTR.valid) && !$past(INSTR.group_start))
        else $error("check forward without a same group reader");
    branch_fwd_a: assert property (BRANCH_FWD |-> $past(INSTR.valid)
        && ($past(INSTR.is_branch) || $past(INSTR.is_brp_ind)) && !$past(INSTR.group_start))
        else $error("branch forward without a branch reader");
endmodule // dep_rule_monitor

bind instr_group_dependency_checker dep_rule_monitor #(.DETECT_EN(DETECT_EN)) mon (
    .CLK(CLK), .SRST(SRST), .INSTR(INSTR), .INSTR_TAG(INSTR_TAG), .FAULT(FAULT),
    .FP_STATUS(FP_STATUS), .FRAME_FWD(FRAME_FWD), .CHECK_FWD(CHECK_FWD),
    .BRANCH_FWD(BRANCH_FWD));
`default_nettype wire

// *** dv/decode_feed.sv ***
/*
 * Decode stage model: hands each pushed record to the checker one cycle
 * later. Assumes the bench orders the stream as decode would.
 */
`timescale 1ns/100ps
`default_nettype none
module decode_feed (
    input wire logic clk,
    input wire logic push,
    input wire dep_check_pkg::instr_s rec,
    input wire logic [7:0] tag,
    output dep_check_pkg::instr_s instr,
    output logic [7:0] instr_tag
);
    initial begin
        instr = '0;
        instr_tag = 8'h00;
    end
    // Idle slots carry flipped junk, so only valid may qualify a record
    always @(posedge clk) begin
        if (push) begin
            instr <= rec;
            instr_tag <= tag;
        end else begin
            instr <= {1'b0, ~instr[$bits(instr)-2:0]};
            instr_tag <= ~instr_tag;
        end
    end
endmodule // decode_feed
`default_nettype wire

// *** dv/instr_group_dependency_checker_tb.sv ***
/*
 * Self-checking bench: pairs of instructions from a table, then redirect,
 * entry point, status merge and reset cases. Assumes the decode model.
 */
`timescale 1ns/100ps
`default_nettype none
`include "dep_check_params.svh"
module instr_group_dependency_checker_tb;
    typedef struct {
        dep_check_pkg::instr_s a;
        dep_check_pkg::instr_s b;
        logic [5:0] ex;
    } row_s;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic push = 1'b0;
    logic [7:0] tag = 8'h00;
    logic [7:0] instr_tag;
    logic frame_fwd;
    logic check_fwd;
    logic branch_fwd;
    logic [`FPS_BITS-1:0] fp_status;
    dep_check_pkg::instr_s rec = '0;
    dep_check_pkg::instr_s instr;
    dep_check_pkg::fault_s fault;
    row_s rows[$];
    int n_fail = 0;
    int checks = 0;

    decode_feed feed (.clk(clk), .push(push), .rec(rec), .tag(tag), .instr(instr),
        .instr_tag(instr_tag));
    instr_group_dependency_checker #(.DETECT_EN(1'b1)) dut (.CLK(clk), .SRST(srst),
        .INSTR(instr), .INSTR_TAG(instr_tag), .FAULT(fault), .FP_STATUS(fp_status),
        .FRAME_FWD(frame_fwd), .CHECK_FWD(check_fwd), .BRANCH_FWD(branch_fwd));

    initial forever #2.5 clk = ~clk;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Flag map, low bit first: branch loop modloop fp hint resize qp_off
    // p_rd p_wr b_rd b_wr frame_rd/wr pfs_rd/wr lc_rd/wr move_rd/wr fill spill
    // all_pred_rd check_load, then the compare class in the top two bits
    function automatic dep_check_pkg::instr_s mk(input logic [24:0] f,
        input logic [5:0] p = 6'h05, input logic [2:0] b = 3'h2, input logic [5:0] nb = 6'h03);
        dep_check_pkg::instr_s r;
        r = '0;
        r.valid = 1'b1;
        {r.is_frame_resize, r.is_brp_ind, r.is_fp, r.is_mod_loop, r.is_loop_branch,
            r.is_branch} = f[5:0];
        r.pred_on = !f[6];
        r.pred_rd[p] = f[7];
        r.pred_wr[p] = f[8];
        r.br_rd[b] = f[9];
        r.br_wr[b] = f[10];
        {r.nat_spill_wr, r.nat_fill_rd, r.nat_move_wr, r.nat_move_rd, r.lc_wr, r.lc_rd,
            r.pfs_wr, r.pfs_rd, r.frame_wr, r.frame_rd} = f[20:11];
        if (f[21]) r.pred_rd = '1;
        r.is_check_load = f[22];
        r.cmp_type = f[24:23];
        r.nat_bit = nb;
        return r;
    endfunction

    task add(input dep_check_pkg::instr_s a, input dep_check_pkg::instr_s b,
        input logic [5:0] e);
        a.group_start = 1'b1;
        rows.push_back('{a, b, e});
    endtask

    task issue(input dep_check_pkg::instr_s r, input logic [7:0] t);
        @(posedge clk);
        push <= 1'b1;
        rec <= r;
        tag <= t;
    endtask

    task settle;
        @(posedge clk);
        push <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task give_verdict;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    // Expected code: fault, kind(2), frame, check, branch forward
    initial begin : main
        dep_check_pkg::instr_s w;
        add(mk(25'h0001020), mk(25'h0000800), 6'h04);
        add(mk(25'h0000400), mk(25'h0000201), 6'h01);
        add(mk(25'h0004000), mk(25'h0002001), 6'h01);
        add(mk(25'h1800100), mk(25'h0000081), 6'h01);
        add(mk(25'h0000108), mk(25'h0000081), 6'h28);
        add(mk(25'h0000400), mk(25'h0000441), 6'h00);
        add(mk(25'h0010000), mk(25'h0010043), 6'h30);
        add(mk(25'h0000401), mk(25'h0000210), 6'h28);
        add(mk(25'h0100000), mk(25'h0080000, 6'h05, 3'h2, 6'h04), 6'h00);
        add(mk(25'h0100000), mk(25'h0080000), 6'h28);
        add(mk(25'h0100000), mk(25'h0020000), 6'h28);
        add(mk(25'h0100000), mk(25'h0100000, 6'h05, 3'h2, 6'h04), 6'h00);
        add(mk(25'h0100000), mk(25'h0100000), 6'h30);
        add(mk(25'h0100000), mk(25'h0040000), 6'h30);
        add(mk(25'h0800100), mk(25'h0800100), 6'h00);
        add(mk(25'h1000100), mk(25'h1000100), 6'h00);
        add(mk(25'h0800100), mk(25'h1000100), 6'h30);
        add(mk(25'h0800100, 6'h00), mk(25'h1000100, 6'h00), 6'h00);
        add(mk(25'h1800100), mk(25'h0000100, 6'h06), 6'h00);
        add(mk(25'h0000100), mk(25'h0000100), 6'h30);
        add(mk(25'h0000100), mk(25'h0200000), 6'h28);
        add(mk(25'h0000081, 6'h3F), mk(25'h0000107, 6'h3F), 6'h38);
        add(mk(25'h0010000), mk(25'h0008001), 6'h28);
        add(mk(25'h0400000), mk(25'h0000000), 6'h02);
        add(mk(25'h0000401), mk(25'h0000201), 6'h28);
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        chk("reset", 16'h0000, 16'({fault, frame_fwd, check_fwd, branch_fwd}));
        foreach (rows[i]) begin
            issue(rows[i].a, 8'(2 * i));
            issue(rows[i].b, 8'(2 * i + 1));
            settle;
            chk("pair", 16'(rows[i].ex),
                16'({fault.fault, fault.kind, frame_fwd, check_fwd, branch_fwd}));
            if (rows[i].ex[5]) chk("tag", 16'(2 * i + 1), 16'(fault.tag));
        end
        // A taken redirect between writer and reader hides the violation
        w = mk(25'h0000108);
        w.group_start = 1'b1;
        issue(w, 8'hA0);
        w = mk(25'h0000000);
        w.is_redirect = 1'b1;
        issue(w, 8'hA1);
        issue(mk(25'h0000081), 8'hA2);
        settle;
        chk("redirect", 16'h0000, 16'(fault.fault));
        w = mk(25'h0000108);
        w.group_start = 1'b1;
        issue(w, 8'hB0);
        w = mk(25'h0000081);
        w.group_start = 1'b1;
        issue(w, 8'hB1);
        settle;
        chk("entry", 16'h0000, 16'(fault.fault));
        w = mk(25'h0000008);
        w.group_start = 1'b1;
        w.fp_status = 16'h0003;
        issue(w, 8'hC0);
        w.group_start = 1'b0;
        w.fp_status = 16'h0104;
        issue(w, 8'hC1);
        w = mk(25'h0000000);
        w.group_start = 1'b1;
        issue(w, 8'hC2);
        settle;
        repeat (2) @(posedge clk);
        #1;
        chk("fp_status", 16'h0107, 16'(fp_status));
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        chk("fp_reset", 16'h0000, 16'(fp_status));
        give_verdict;
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        give_verdict;
    end
endmodule // instr_group_dependency_checker_tb
`default_nettype wire
